// File: common/hdlc_irq_consts.vh
// Constants for the HDLC interrupt, check-sequence and byte-count block
`ifndef HDLC_IRQ_CONSTS_VH
`define HDLC_IRQ_CONSTS_VH

// Page codes that select one of the two controller copies
`define PAGE_FIRST        8'h0b
`define PAGE_SECOND       8'h0c

// Register indices; byte address is four times the index
`define IDX_CTRL2         8'h15
`define IDX_MASK          8'h16
`define IDX_FLAGS         8'h17
`define IDX_CHECK_UPPER   8'h18
`define IDX_CHECK_LOWER   8'h19
`define IDX_TX_COUNT      8'h1a

// Address fields: index in bits 9:2, page in bits 17:10
`define ADDR_IDX_LSB      2
`define ADDR_PAGE_LSB     10

// Event flag bit positions (mask bits share them)
`define FLAG_GO_AHEAD     7
`define FLAG_RX_END       6
`define FLAG_TX_DONE      5
`define FLAG_LAST_NEXT    4
`define FLAG_TX_LOW       3
`define FLAG_ABORT_UNDER  2
`define FLAG_RX_HIGH      1
`define FLAG_RX_OVERRUN   0

// Second control register bits
`define CTRL2_INTSEL      7
`define CTRL2_CYCLE       6

// Reset values
`define MASK_RESET        8'h00
`define FLAGS_RESET       8'h00
`define CTRL2_RESET       8'h00
`define TX_COUNT_RESET    8'h00
`define CHECK_RESET       8'h00

// Counts
`define ABORT_MIN_BITS    5'd26
`define RX_FIFO_DEPTH     8'h80
`define TX_COUNT_ONE      8'h01
`define TX_COUNT_ZERO     8'h00

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: hdl/hdlc_irq_crc_bytecount.v
// Event flags, masks, check-sequence capture and tx byte counter, two copies
`timescale 1ns/10ps
`default_nettype none
`include "hdlc_irq_consts.vh"

module hdlc_irq_crc_bytecount #(
  parameter ADDR_W = 18,                     // Bus address width
  parameter CNT_W  = 8                       // Tx byte counter width
) (
  // Clock and reset
  input  wire                 aclk,
  input  wire                 aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0]    s_axi_awaddr,
  input  wire [2:0]           s_axi_awprot,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0]    s_axi_araddr,
  input  wire [2:0]           s_axi_arprot,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // Receiver events, one bit per controller, and check words, 16 bits each
  input  wire [1:0]           go_ahead_seen,
  input  wire [1:0]           rx_end_byte_write,
  input  wire [1:0]           rx_flag_detected,
  input  wire [1:0]           rx_bit_strobe,
  input  wire [1:0]           rx_frame_abort,
  input  wire [1:0]           rx_packet_end,
  input  wire [31:0]          rx_check_in,
  // Receive FIFO side
  input  wire [1:0]           last_byte_next,
  input  wire [1:0]           rx_empty_read,
  input  wire [1:0]           rx_fifo_above_full,
  input  wire [1:0]           rx_fifo_write_try,
  input  wire [15:0]          rx_fifo_level,
  // Transmitter and transmit FIFO side
  input  wire [1:0]           tx_packet_done,
  input  wire [1:0]           tx_fifo_below_low,
  input  wire [1:0]           tx_underrun_read,
  input  wire [1:0]           tx_fifo_write,
  // Results
  output reg  [1:0]           irq,
  output reg  [1:0]           rx_disabled,
  output reg  [1:0]           packet_end_tag,
  output reg  [15:0]          ctrl2_out
);

  ////////////////////////////////////////////////////////////////////////////
  // How the block hangs together
  //
  // Every register exists twice, one copy per link controller; the page
  // field of the bus address picks the copy, the index field the register.
  // Event strobes come from logic on this same clock, so they are used as
  // they stand, with no synchronising stages.
  //
  // Flags are sticky: an event sets its bit whatever the mask says, and
  // only a read of the flag register clears them. A read and an event in
  // one cycle leave the flag set, so no event is lost between the read
  // data being captured and the clear taking effect.
  //
  // The request output is a registered OR of the flags ANDed with the mask, built from
  // the next flag value, so it rises on the same edge as its flag.
  //
  // Limitation: the abort bit count saturates at the minimum, so it tells
  // only whether a frame was long enough, not how long it was.

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Page field to controller copy; only two pages are mapped
  function page_known;
    input [ADDR_W-1:0] addr;
    begin
      page_known = (addr[`ADDR_PAGE_LSB +: 8] == `PAGE_FIRST) ||
                   (addr[`ADDR_PAGE_LSB +: 8] == `PAGE_SECOND);
    end
  endfunction

  // Selected copy, 0 or 1
  function page_sel;
    input [ADDR_W-1:0] addr;
    begin
      page_sel = (addr[`ADDR_PAGE_LSB +: 8] == `PAGE_SECOND);
    end
  endfunction

  // Register index field
  function [7:0] reg_idx;
    input [ADDR_W-1:0] addr;
    begin
      reg_idx = addr[`ADDR_IDX_LSB +: 8];
    end
  endfunction

  // Unmapped pages and indices answer with an error and change nothing
  // Whether an index names a register of this block
  function idx_known;
    input [7:0] idx;
    begin
      idx_known = (idx >= `IDX_CTRL2) && (idx <= `IDX_TX_COUNT);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage, one entry per controller copy

  reg  [7:0]       mask      [0:1];    // Event interrupt enables
  reg  [7:0]       flags     [0:1];    // Sticky event flags
  reg  [7:0]       ctrl2     [0:1];    // Second control register
  reg  [7:0]       check_hi  [0:1];    // Received check, upper byte
  reg  [7:0]       check_lo  [0:1];    // Received check, lower byte
  reg  [CNT_W-1:0] tx_length_counter [0:1]; // Live down-counter
  reg  [CNT_W-1:0] tx_length_prog    [0:1]; // Programmed length
  reg  [4:0]       rx_bits   [0:1];    // Bits since flag, saturating

  // Write channel holding state
  reg  [ADDR_W-1:0] aw_addr;           // Captured write address
  reg               aw_held;           // Write address in hand
  reg  [31:0]       w_data;            // Captured write data
  reg  [3:0]        w_strb;            // Captured byte strobes
  reg               w_held;            // Write data in hand

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes: writes from the holding state, reads from the live bus

  wire       do_write = aw_held && w_held && !s_axi_bvalid;
  wire       wr_ok    = page_known(aw_addr) && idx_known(reg_idx(aw_addr));
  wire       wr_copy  = page_sel(aw_addr);
  wire [7:0] wr_idx   = reg_idx(aw_addr);
  // Only the low lane carries register data; upper lanes are ignored
  wire       wr_lane  = w_strb[0];
  wire       do_read  = s_axi_arvalid && s_axi_arready;
  wire       rd_ok    = page_known(s_axi_araddr) &&
                        idx_known(reg_idx(s_axi_araddr));
  wire       rd_copy  = page_sel(s_axi_araddr);
  wire [7:0] rd_idx   = reg_idx(s_axi_araddr);

  ////////////////////////////////////////////////////////////////////////////
  // Event vectors and next values, both copies

  reg  [7:0]       ev          [0:1];  // Events seen this cycle
  reg  [7:0]       next_flags  [0:1];  // Flags after set and clear
  reg  [CNT_W-1:0] next_count  [0:1];  // Counter after this cycle
  reg  [7:0]       rd_value;           // Read mux result
  integer          k;

  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      ev[k] = 8'h00;
      ev[k][`FLAG_GO_AHEAD]   = go_ahead_seen[k];
      ev[k][`FLAG_RX_END]     = rx_end_byte_write[k];
      ev[k][`FLAG_TX_DONE]    = tx_packet_done[k];
      ev[k][`FLAG_LAST_NEXT]  = last_byte_next[k] |
                                rx_empty_read[k];
      ev[k][`FLAG_TX_LOW]     = tx_fifo_below_low[k];
      // Source of bit 2 follows the select bit
      if (ctrl2[k][`CTRL2_INTSEL]) begin
        ev[k][`FLAG_ABORT_UNDER] = tx_underrun_read[k];
      end else begin
        // Short aborts are noise, not frames
        ev[k][`FLAG_ABORT_UNDER] = rx_frame_abort[k] &&
                                   (rx_bits[k] >= `ABORT_MIN_BITS);
      end
      ev[k][`FLAG_RX_HIGH]    = rx_fifo_above_full[k];
      ev[k][`FLAG_RX_OVERRUN] = rx_fifo_write_try[k] &&
        (rx_fifo_level[k*8 +: 8] == `RX_FIFO_DEPTH);
      // Set wins over clear, so a strobe during the read is kept
      // Clear on read, but a same-cycle event survives
      next_flags[k] = flags[k];
      if (do_read && rd_ok && rd_copy == k[0] &&
          rd_idx == `IDX_FLAGS) begin
        next_flags[k] = `FLAGS_RESET;
      end
      next_flags[k] = next_flags[k] | ev[k];
      // A count of zero is parked: further writes leave it at zero and
      // raise no tag, so an unprogrammed counter never marks a byte
      // Counter: software load wins over a FIFO write
      next_count[k] = tx_length_counter[k];
      if (do_write && wr_ok && wr_lane && wr_copy == k[0] &&
          wr_idx == `IDX_TX_COUNT) begin
        // Stored data, not the live bus: wdata may have moved on by now
        next_count[k] = w_data[CNT_W-1:0];
      end else if (tx_fifo_write[k] &&
                   tx_length_counter[k] != `TX_COUNT_ZERO) begin
        if (tx_length_counter[k] == `TX_COUNT_ONE &&
            ctrl2[k][`CTRL2_CYCLE]) begin
          next_count[k] = tx_length_prog[k];
        end else begin
          next_count[k] = tx_length_counter[k] - `TX_COUNT_ONE;
        end
      end
    end
  end

  // Read data mux for the addressed copy
  always @* begin
    case (rd_idx)
      `IDX_CTRL2:       rd_value = ctrl2[rd_copy];
      `IDX_MASK:        rd_value = mask[rd_copy];
      `IDX_FLAGS:       rd_value = flags[rd_copy];
      `IDX_CHECK_UPPER: rd_value = check_hi[rd_copy];
      `IDX_CHECK_LOWER: rd_value = check_lo[rd_copy];
      `IDX_TX_COUNT:    rd_value = tx_length_counter[rd_copy];
      default:          rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      // Ready only while the slot is free, so payloads are never lost
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Both halves are latched first, so the master may offer address
      // and data in either order or in the same cycle
      // Response once both halves are in hand
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one-cycle answer

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      // Read data is captured on the take edge; the flag clear lands on
      // the same edge, so software always sees exactly what it clears
      // One read in flight at a time
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_ok ? rd_value : 8'h00};
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-copy registers, flags and counters

  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 2; i = i + 1) begin
        mask[i]              <= `MASK_RESET;
        flags[i]             <= `FLAGS_RESET;
        ctrl2[i]             <= `CTRL2_RESET;
        check_hi[i]          <= `CHECK_RESET;
        check_lo[i]          <= `CHECK_RESET;
        tx_length_counter[i] <= `TX_COUNT_RESET;
        tx_length_prog[i]    <= `TX_COUNT_RESET;
        rx_bits[i]           <= 5'd0;
      end
      irq            <= 2'b00;
      rx_disabled    <= 2'b00;
      packet_end_tag <= 2'b00;
      ctrl2_out      <= 16'h0000;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // Software writes land in the copy picked by the page
        if (do_write && wr_ok && wr_lane && wr_copy == i[0]) begin
          case (wr_idx)
            `IDX_CTRL2: ctrl2[i] <= w_data[7:0];
            `IDX_MASK:  mask[i]  <= w_data[7:0];
            `IDX_TX_COUNT: tx_length_prog[i] <= w_data[CNT_W-1:0];
            default: ;
          endcase
        end
        flags[i]             <= next_flags[i];
        tx_length_counter[i] <= next_count[i];
        // Capture check bytes untouched at each packet end
        if (rx_packet_end[i]) begin
          check_hi[i] <= rx_check_in[i*16+8 +: 8];
          check_lo[i] <= rx_check_in[i*16 +: 8];
        end
        // Bit count since the last flag, held at the abort minimum
        if (rx_flag_detected[i]) begin
          rx_bits[i] <= 5'd0;
        end else if (rx_bit_strobe[i] && rx_bits[i] < `ABORT_MIN_BITS) begin
          rx_bits[i] <= rx_bits[i] + 5'd1;
        end
        // Overrun holds the receiver off until the next flag
        if (ev[i][`FLAG_RX_OVERRUN]) begin
          rx_disabled[i] <= 1'b1;
        end else if (rx_flag_detected[i]) begin
          rx_disabled[i] <= 1'b0;
        end
        // Request follows flags with no extra delay, a new mask one edge later
        irq[i] <= |(next_flags[i] & mask[i]);
        // Tag is ready for the very next FIFO write
        packet_end_tag[i] <= (next_count[i] == `TX_COUNT_ONE);
        ctrl2_out[i*8 +: 8] <= ctrl2[i];
      end
      // Mask written this cycle takes effect on the next edge
      // so a write and an event in one cycle use the old mask
    end
  end

endmodule
`default_nettype wire

// File: tb/hdlc_irq_checker_assertions.sv
// Checker for event, count and bus relations of the HDLC block
`timescale 1ns/10ps
`default_nettype none
module hdlc_irq_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Events and results
  input wire logic [1:0]  rx_flag_detected,
  input wire logic [1:0]  rx_fifo_write_try,
  input wire logic [15:0] rx_fifo_level,
  input wire logic [1:0]  tx_fifo_write,
  input wire logic [1:0]  irq,
  input wire logic [1:0]  rx_disabled,
  input wire logic [1:0]  packet_end_tag,
  input wire logic [15:0] ctrl2_out
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  AST_OVR_HOLDS_OFF: assert property (
    rx_fifo_write_try[0] && rx_fifo_level[7:0] == 8'h80 |=> rx_disabled[0])
    else $error("overrun did not hold receiver off");
  AST_OFF_UNTIL_FLAG: assert property (
    rx_disabled[0] && !rx_flag_detected[0] |=> rx_disabled[0])
    else $error("receiver came back without a flag");
  AST_FLAG_REENABLES: assert property (
    rx_flag_detected[0] && !rx_fifo_write_try[0] |=> !rx_disabled[0])
    else $error("flag did not re-enable receiver");
  AST_TAG_CONSUMED: assert property (
    packet_end_tag[0] && tx_fifo_write[0] && !ctrl2_out[6]
    |=> !packet_end_tag[0] || $rose(s_axi_bvalid))
    else $error("tag kept after tagged write");
  AST_TAG_STILL: assert property (
    !tx_fifo_write[0] |=> $stable(packet_end_tag[0]) || $rose(s_axi_bvalid))
    else $error("tag moved without a write");
  // Only a read, or a write settling, may drop a raised request
  AST_IRQ_HOLDS: assert property (
    irq[0] && !(s_axi_arvalid && s_axi_arready) && !s_axi_awvalid
    && !s_axi_wvalid && !s_axi_bvalid |=> irq[0])
    else $error("interrupt dropped without software action");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_ONE_RESPONSE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // Main scenarios reached
  COV_OVERRUN: cover property (rx_disabled[0] ##1 !rx_disabled[0]);
  COV_TAG: cover property ($rose(packet_end_tag[0]));
  COV_IRQ: cover property ($rose(irq[0]));
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the HDLC event, check-byte and count block
`timescale 1ns/10ps
`default_nettype none
`include "hdlc_irq_consts.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
  // Clock, reset and bus master signals
  logic        aclk = 0, aresetn = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rx_check_in = 0, rd_d, v;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp, irq, rx_disabled, packet_end_tag;
  wire  [31:0] rdata;
  wire  [15:0] ctrl2_out;
  // Event strobes, row b drives the source of flag bit b, 8+ the rest
  logic [1:0]  ev [0:13] = '{default: 2'b00};
  logic [1:0]  rsp;
  logic [31:0] seed = 98;
  logic [15:0] lvl = 16'h8080;   // Receive FIFO levels, both copies
  logic [15:0] exp_q [$];        // Expected check words, in order
  integer      error_cnt = 0, checked = 0, k, b, i, cyc, cnt, prg;
  always #5 aclk = ~aclk;
  hdlc_irq_crc_bytecount hdlc_irq_crc_bytecount_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .go_ahead_seen(ev[7]), .rx_end_byte_write(ev[6]),
    .rx_flag_detected(ev[8]), .rx_bit_strobe(ev[9]),
    .rx_frame_abort(ev[10]), .rx_packet_end(ev[11]),
    .rx_check_in(rx_check_in), .last_byte_next(ev[4]),
    .rx_empty_read(ev[13]), .rx_fifo_above_full(ev[1]),
    .rx_fifo_write_try(ev[0]), .rx_fifo_level(lvl),
    .tx_packet_done(ev[5]), .tx_fifo_below_low(ev[3]),
    .tx_underrun_read(ev[2]), .tx_fifo_write(ev[12]), .irq(irq),
    .rx_disabled(rx_disabled), .packet_end_tag(packet_end_tag),
    .ctrl2_out(ctrl2_out));
  ////////////////////////////////////////////////////////////////////////
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Byte address of a register in copy c
  function automatic logic [17:0] ad(input integer c, input logic [7:0] x);
    return {(c != 0 ? `PAGE_SECOND : `PAGE_FIRST), x, 2'b00};
  endfunction
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
    #1;
  endtask
  // Read: address held until taken, rready held until data seen
  task automatic rd(input logic [17:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd_d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    #1;
  endtask
  // Read a register and compare with the model
  task automatic rc(input integer c, input logic [7:0] x, input logic [31:0] e);
    rd(ad(c, x));
    `CHK(rd_d, e)
  endtask
  // One-cycle strobe on event row x of copy c
  task automatic fire(input integer c, input integer x);
    @(posedge aclk);
    ev[x][c] <= 1'b1;
    @(posedge aclk);
    ev[x][c] <= 1'b0;
    #1;
  endtask
  // Counts, verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 2; k++)
      for (i = `IDX_CTRL2; i <= `IDX_TX_COUNT; i++) rc(k, i, 0);
    rd({8'h0d, `IDX_MASK, 2'b00});
    `CHK(rsp, `RESP_SLVERR)
    wr({8'h0d, `IDX_MASK, 2'b00}, 32'hff);
    `CHK(rsp, `RESP_SLVERR)
    rc(0, `IDX_MASK, 0);
    $display("reset and map test done");
    // Bit 2 follows the underrun source during the loop
    for (k = 0; k < 2; k++) wr(ad(k, `IDX_CTRL2), 32'h80);
    `CHK(ctrl2_out, 16'h8080)
    for (k = 0; k < 2; k++)
      for (b = 0; b < 8; b++) begin
        fire(k, b);
        `CHK(irq[k], 1'b0)
        if (b == 0) `CHK(rx_disabled[k], 1'b1)
        fire(k, 8);
        `CHK(rx_disabled, 2'b00)
        rc(1 - k, `IDX_FLAGS, 0);
        rc(k, `IDX_FLAGS, 1 << b);
        rc(k, `IDX_FLAGS, 0);
        wr(ad(k, `IDX_MASK), 1 << b);
        fire(k, b);
        `CHK(irq, 2'b01 << k)
        rc(k, `IDX_FLAGS, 1 << b);
        `CHK(irq[k], 1'b0)
        wr(ad(k, `IDX_MASK), 0);
      end
    fire(0, 13);
    rc(0, `IDX_FLAGS, 8'h10);
    // One byte short of full: a write try is no overrun
    @(posedge aclk);
    lvl <= 16'h7f7f;
    fire(0, 0);
    `CHK(rx_disabled, 2'b00)
    rc(0, `IDX_FLAGS, 0);
    $display("flag test done");
    // Abort counts only after 26 bits since the last flag
    wr(ad(0, `IDX_CTRL2), 0);
    fire(0, 8);
    for (i = 0; i < 26; i++) begin
      if (i == 25) fire(0, 10);
      fire(0, 9);
    end
    rc(0, `IDX_FLAGS, 0);
    fire(0, 10);
    fire(0, 2);
    rc(0, `IDX_FLAGS, 8'h04);
    $display("abort test done");
    // Check bytes captured per packet, read-only
    for (i = 0; i < 4; i++) begin
      v = rnd();
      @(posedge aclk);
      rx_check_in[(i % 2) * 16 +: 16] <= v[15:0];
      fire(i % 2, 11);
      wr(ad(i % 2, `IDX_CHECK_UPPER), ~v);
      exp_q.push_back(v[15:0]);
      rc(i % 2, `IDX_CHECK_UPPER, exp_q[0] >> 8);
      rc(i % 2, `IDX_CHECK_LOWER, exp_q[0] & 8'hff);
      void'(exp_q.pop_front());
    end
    $display("check byte test done");
    // Byte counter, plain in copy 0 and cycling in copy 1
    for (cyc = 0; cyc < 2; cyc++) begin
      wr(ad(cyc, `IDX_CTRL2), cyc << 6);
      `CHK(ctrl2_out[cyc * 8 +: 8], cyc << 6)
      prg = 2 + rnd() % 4;
      cnt = prg;
      wr(ad(cyc, `IDX_TX_COUNT), prg);
      for (i = 0; i < prg + 2; i++) begin
        fire(cyc, 12);
        cnt = (cnt == 0) ? 0 : (cnt == 1 && cyc == 1) ? prg : cnt - 1;
        `CHK(packet_end_tag[cyc], cnt == 1)
        rc(cyc, `IDX_TX_COUNT, cnt);
      end
    end
    $display("byte count test done");
    // Reset in mid-run clears the enables again
    wr(ad(1, `IDX_MASK), 32'hff);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(1, `IDX_MASK, 0);
    $display("second reset test done");
    complete_run;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    complete_run;
  end
endmodule
bind hdlc_irq_crc_bytecount hdlc_irq_checker chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .rx_flag_detected(rx_flag_detected), .rx_fifo_level(rx_fifo_level),
  .rx_fifo_write_try(rx_fifo_write_try), .tx_fifo_write(tx_fifo_write),
  .irq(irq), .rx_disabled(rx_disabled), .packet_end_tag(packet_end_tag),
  .ctrl2_out(ctrl2_out));
`default_nettype wire
